// >>> rtl/intc_pkg.sv
package intc_pkg;
	localparam int PIN_COUNT = 8;
	localparam int LEVEL_COUNT = 8;
	localparam int LEVEL_W = 3;
	localparam int PEND_W = 32;
	localparam int PIN0_BIT = 31;
	localparam int SRC_COUNT = 6;
	// internal source slots in the status and level vectors
	localparam int SRC_TB_FIRST = 0;
	localparam int SRC_TB_SECOND = 1;
	localparam int SRC_ALARM = 2;
	localparam int SRC_SECONDS = 3;
	localparam int SRC_PERIODIC = 4;
	localparam int SRC_LOCK = 5;
	// offset of the non-maskable vector inside the exception table
	localparam logic [15:0] NMI_VECTOR_OFFSET = 16'h0100;
	// mask value that enables level 5 only
	localparam logic [31:0] LEVEL5_MASK_VALUE = 32'h00100000;
	// reset values
	localparam logic [31:0] PENDING_RESET = 32'h00000000;
	localparam logic [31:0] COUNT32_RESET = 32'h00000000;
	localparam logic [15:0] COUNT16_RESET = 16'h0000;
	// timing
	localparam longint CLOCK_FREQ_HZ = 200000000;
	localparam longint SECOND_TIME_S = 1;
	localparam longint SECOND_CYCLES = CLOCK_FREQ_HZ * SECOND_TIME_S;
	localparam int TB_DIVIDE_DEFAULT = 16;
	localparam int PIT_DIVIDE_DEFAULT = 4;
endpackage : intc_pkg

// >>> rtl/pin_request_detect.sv
`timescale 1ns/10ps
module pin_request_detect (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic pin_n,
	input wire logic edge_mode,
	input wire logic clear,
	output logic pending
);
	logic prev_pin_n;

	// previous pin level, idle high
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prev_pin_n <= 1'b1;
		end else begin
			prev_pin_n <= pin_n;
		end
	end

	// edge mode is sticky so a short pulse is not missed; level mode follows the pin
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pending <= 1'b0;
		end else if (edge_mode) begin
			if (prev_pin_n && !pin_n) begin
				pending <= 1'b1;
			end else if (clear) begin
				pending <= 1'b0;
			end
		end else begin
			pending <= !pin_n;
		end
	end
endmodule : pin_request_detect

// >>> rtl/status_flag.sv
`timescale 1ns/10ps
module status_flag (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic set,
	input wire logic clear,
	output logic flag
);
	// sticky until software clears; an event in the clearing cycle wins
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end
endmodule : status_flag

// >>> rtl/system_interrupt_source_aggregator.sv
`timescale 1ns/10ps
module system_interrupt_source_aggregator #(
	parameter longint unsigned SECOND_CYCLES = intc_pkg::SECOND_CYCLES,
	parameter int unsigned TB_DIVIDE = intc_pkg::TB_DIVIDE_DEFAULT,
	parameter int unsigned PIT_DIVIDE = intc_pkg::PIT_DIVIDE_DEFAULT
) (
	input wire logic CLOCK,
	input wire logic ARST_N,
	// request pins, active low
	input wire logic [intc_pkg::PIN_COUNT-1:0] IRQ_N,
	input wire logic [intc_pkg::PIN_COUNT-1:0] PIN_EDGE_MODE,
	input wire logic [intc_pkg::PIN_COUNT-1:0] PIN_CLEAR,
	// interrupt_mask_reg contents
	input wire logic [intc_pkg::PEND_W-1:0] INTERRUPT_MASK,
	// time base
	input wire logic [31:0] TB_REF0,
	input wire logic [31:0] TB_REF1,
	input wire logic [intc_pkg::LEVEL_W-1:0] TIMEBASE_LEVEL_FIELD,
	input wire logic TIMEBASE_MATCH_FIRST_ENABLE,
	input wire logic TIMEBASE_MATCH_SECOND_ENABLE,
	input wire logic TIMEBASE_MATCH_FIRST_CLEAR,
	input wire logic TIMEBASE_MATCH_SECOND_CLEAR,
	// real-time clock
	input wire logic [31:0] ALARM_VALUE,
	input wire logic [intc_pkg::LEVEL_W-1:0] CLOCK_LEVEL_FIELD,
	input wire logic ALARM_ENABLE,
	input wire logic SECONDS_ENABLE,
	input wire logic ALARM_CLEAR,
	input wire logic SECONDS_CLEAR,
	// periodic timer
	input wire logic PERIODIC_TIMER_RUN,
	input wire logic [15:0] PERIODIC_TIMER_RELOAD,
	input wire logic [intc_pkg::LEVEL_W-1:0] PERIODIC_TIMER_LEVEL_FIELD,
	input wire logic PERIODIC_TIMER_ENABLE,
	input wire logic PERIODIC_TIMER_CLEAR,
	// pll lock detector
	input wire logic PLL_LOCKED,
	input wire logic [intc_pkg::LEVEL_W-1:0] LOCK_CHANGE_LEVEL_FIELD,
	input wire logic LOCK_CHANGE_ENABLE,
	input wire logic LOCK_CHANGE_CLEAR,
	// results
	output logic [intc_pkg::PEND_W-1:0] INTERRUPT_PENDING,
	output logic CORE_IRQ,
	output logic NMI_REQ,
	output logic [15:0] NMI_VECTOR,
	output logic [intc_pkg::SRC_COUNT-1:0] SOURCE_FLAGS,
	output logic [31:0] TIMEBASE_COUNT,
	output logic [31:0] CLOCK_COUNT,
	output logic [15:0] PERIODIC_TIMER_COUNT
);
	import intc_pkg::*;

	logic [PIN_COUNT-1:0] pin_pending;
	logic [SRC_COUNT-1:0] src_set;
	logic [SRC_COUNT-1:0] src_clear;
	logic [SRC_COUNT-1:0] src_flag;
	logic [SRC_COUNT-1:0] src_enable;
	logic [LEVEL_W-1:0] src_level [0:SRC_COUNT-1];
	logic [LEVEL_COUNT-1:0] level_pending;
	logic [PEND_W-1:0] next_interrupt_pending;
	logic [PEND_W-1:0] core_gate;
	logic [31:0] tb_div;
	logic tb_tick;
	logic [31:0] sec_div;
	logic sec_tick;
	logic [31:0] pit_div;
	logic pit_tick;
	logic [31:0] next_tb_count;
	logic [31:0] next_clock_count;
	logic prev_locked;
	logic lock_primed;

	// one detector per pin, pin 0 included so it also posts to pending
	genvar gp;
	generate
		for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
			pin_request_detect u_pin (
				.clock(CLOCK),
				.arst_n(ARST_N),
				.pin_n(IRQ_N[gp]),
				.edge_mode(PIN_EDGE_MODE[gp]),
				.clear(PIN_CLEAR[gp]),
				.pending(pin_pending[gp])
			);
		end
	endgenerate

	// time base prescaler, one-cycle tick
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			tb_div <= COUNT32_RESET;
			tb_tick <= 1'b0;
		end else if (tb_div == 32'(TB_DIVIDE - 1)) begin
			tb_div <= COUNT32_RESET;
			tb_tick <= 1'b1;
		end else begin
			tb_div <= tb_div + 32'h00000001;
			tb_tick <= 1'b0;
		end
	end

	// seconds prescaler for the real-time clock
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			sec_div <= COUNT32_RESET;
			sec_tick <= 1'b0;
		end else if (sec_div == 32'(SECOND_CYCLES - 1)) begin
			sec_div <= COUNT32_RESET;
			sec_tick <= 1'b1;
		end else begin
			sec_div <= sec_div + 32'h00000001;
			sec_tick <= 1'b0;
		end
	end

	// periodic timer prescaler
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			pit_div <= COUNT32_RESET;
			pit_tick <= 1'b0;
		end else if (pit_div == 32'(PIT_DIVIDE - 1)) begin
			pit_div <= COUNT32_RESET;
			pit_tick <= 1'b1;
		end else begin
			pit_div <= pit_div + 32'h00000001;
			pit_tick <= 1'b0;
		end
	end

	assign next_tb_count = TIMEBASE_COUNT + 32'h00000001;
	assign next_clock_count = CLOCK_COUNT + 32'h00000001;

	// free-running time base, wraps silently
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			TIMEBASE_COUNT <= COUNT32_RESET;
		end else if (tb_tick) begin
			TIMEBASE_COUNT <= next_tb_count;
		end
	end

	// seconds counter of the real-time clock
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			CLOCK_COUNT <= COUNT32_RESET;
		end else if (sec_tick) begin
			CLOCK_COUNT <= next_clock_count;
		end
	end

	// down counter reloads on the tick after zero; a reload of zero never fires
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			PERIODIC_TIMER_COUNT <= COUNT16_RESET;
		end else if (pit_tick && PERIODIC_TIMER_RUN) begin
			if (PERIODIC_TIMER_COUNT == COUNT16_RESET) begin
				PERIODIC_TIMER_COUNT <= PERIODIC_TIMER_RELOAD;
			end else begin
				PERIODIC_TIMER_COUNT <= PERIODIC_TIMER_COUNT - 16'h0001;
			end
		end
	end

	// lock history; primed keeps the first sample after reset from looking like a change
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			prev_locked <= 1'b0;
			lock_primed <= 1'b0;
		end else begin
			prev_locked <= PLL_LOCKED;
			lock_primed <= 1'b1;
		end
	end

	// events that set the status flags; compare on the count being loaded
	assign src_set[SRC_TB_FIRST] = tb_tick && (next_tb_count == TB_REF0);
	assign src_set[SRC_TB_SECOND] = tb_tick && (next_tb_count == TB_REF1);
	assign src_set[SRC_ALARM] = sec_tick && (next_clock_count == ALARM_VALUE);
	assign src_set[SRC_SECONDS] = sec_tick;
	assign src_set[SRC_PERIODIC] = pit_tick && PERIODIC_TIMER_RUN && (PERIODIC_TIMER_COUNT == 16'h0001);
	assign src_set[SRC_LOCK] = lock_primed && (prev_locked != PLL_LOCKED);

	// software clear strobes
	assign src_clear[SRC_TB_FIRST] = TIMEBASE_MATCH_FIRST_CLEAR;
	assign src_clear[SRC_TB_SECOND] = TIMEBASE_MATCH_SECOND_CLEAR;
	assign src_clear[SRC_ALARM] = ALARM_CLEAR;
	assign src_clear[SRC_SECONDS] = SECONDS_CLEAR;
	assign src_clear[SRC_PERIODIC] = PERIODIC_TIMER_CLEAR;
	assign src_clear[SRC_LOCK] = LOCK_CHANGE_CLEAR;

	// per-source enables
	assign src_enable[SRC_TB_FIRST] = TIMEBASE_MATCH_FIRST_ENABLE;
	assign src_enable[SRC_TB_SECOND] = TIMEBASE_MATCH_SECOND_ENABLE;
	assign src_enable[SRC_ALARM] = ALARM_ENABLE;
	assign src_enable[SRC_SECONDS] = SECONDS_ENABLE;
	assign src_enable[SRC_PERIODIC] = PERIODIC_TIMER_ENABLE;
	assign src_enable[SRC_LOCK] = LOCK_CHANGE_ENABLE;

	// level fields; the two time base and the two clock sources share one each
	assign src_level[SRC_TB_FIRST] = TIMEBASE_LEVEL_FIELD;
	assign src_level[SRC_TB_SECOND] = TIMEBASE_LEVEL_FIELD;
	assign src_level[SRC_ALARM] = CLOCK_LEVEL_FIELD;
	assign src_level[SRC_SECONDS] = CLOCK_LEVEL_FIELD;
	assign src_level[SRC_PERIODIC] = PERIODIC_TIMER_LEVEL_FIELD;
	assign src_level[SRC_LOCK] = LOCK_CHANGE_LEVEL_FIELD;

	// one sticky flag per internal source
	genvar gs;
	generate
		for (gs = 0; gs < SRC_COUNT; gs++) begin : g_src
			status_flag u_flag (
				.clock(CLOCK),
				.arst_n(ARST_N),
				.set(src_set[gs]),
				.clear(src_clear[gs]),
				.flag(src_flag[gs])
			);
		end
	endgenerate

	// a level is pending while any enabled flag assigned to it stands
	always_comb begin
		level_pending = '0;
		for (int l = 0; l < LEVEL_COUNT; l++) begin
			for (int s = 0; s < SRC_COUNT; s++) begin
				if (src_flag[s] && src_enable[s] && (src_level[s] == LEVEL_W'(l))) begin
					level_pending[l] = 1'b1;
				end
			end
		end
	end

	// interleave pin i and level i from the top bit down; low half reads zero
	always_comb begin
		next_interrupt_pending = PENDING_RESET;
		for (int i = 0; i < PIN_COUNT; i++) begin
			next_interrupt_pending[PIN0_BIT - 2 * i] = pin_pending[i];
			next_interrupt_pending[PIN0_BIT - 2 * i - 1] = level_pending[i];
		end
	end

	// pin 0 goes to the non-maskable path, not through the mask
	always_comb begin
		core_gate = INTERRUPT_MASK;
		core_gate[PIN0_BIT] = 1'b0;
	end

	// pending image; bit order alone gives priority, so leading-zero count finds the winner
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			INTERRUPT_PENDING <= PENDING_RESET;
		end else begin
			INTERRUPT_PENDING <= next_interrupt_pending;
		end
	end

	// core request registered alongside pending so both change on the same edge
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			CORE_IRQ <= 1'b0;
		end else begin
			CORE_IRQ <= |(next_interrupt_pending & core_gate);
		end
	end

	// non-maskable request ignores every mask and enable
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			NMI_REQ <= 1'b0;
			NMI_VECTOR <= NMI_VECTOR_OFFSET;
		end else begin
			NMI_REQ <= pin_pending[0];
			NMI_VECTOR <= NMI_VECTOR_OFFSET;
		end
	end

	// flags shown to software for its handler
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			SOURCE_FLAGS <= '0;
		end else begin
			SOURCE_FLAGS <= src_flag;
		end
	end
endmodule : system_interrupt_source_aggregator

// >>> verif/core_model.sv
`timescale 1ns/10ps
module core_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic irq,
	input wire logic nmi,
	output logic [31:0] irq_count,
	output logic [31:0] nmi_count
);
	logic irq_seen;
	logic nmi_seen;
	// the core takes a held request once, on its rise
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_seen <= 1'h0;
			nmi_seen <= 1'h0;
			irq_count <= 32'h0;
			nmi_count <= 32'h0;
		end else begin
			irq_seen <= irq;
			nmi_seen <= nmi;
			irq_count <= irq_count + {31'h0, irq && !irq_seen};
			nmi_count <= nmi_count + {31'h0, nmi && !nmi_seen};
		end
	end
endmodule : core_model

// >>> verif/intc_checker_asserts.sv
`timescale 1ns/10ps
module intc_checker (
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic [7:0] IRQ_N,
	input wire logic [7:0] PIN_EDGE_MODE,
	input wire logic [31:0] INTERRUPT_MASK,
	input wire logic [31:0] TB_REF0,
	input wire logic PLL_LOCKED,
	input wire logic [31:0] INTERRUPT_PENDING,
	input wire logic CORE_IRQ,
	input wire logic NMI_REQ,
	input wire logic [15:0] NMI_VECTOR,
	input wire logic [5:0] SOURCE_FLAGS,
	input wire logic [31:0] TIMEBASE_COUNT,
	input wire logic [15:0] PERIODIC_TIMER_COUNT
);
	import intc_pkg::*;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	// pin three low in level mode, detector stage then output stage
	sequence s_low3;
		!IRQ_N[3] && !PIN_EDGE_MODE[3];
	endsequence
	sequence s_fall3;
		$fell(IRQ_N[3]) && PIN_EDGE_MODE[3];
	endsequence
	property p_nmi; NMI_REQ == INTERRUPT_PENDING[31]; endproperty
	property p_vec; NMI_VECTOR == NMI_VECTOR_OFFSET; endproperty
	// mask is one stage ahead of the output register
	property p_irq; CORE_IRQ == |(INTERRUPT_PENDING & $past(INTERRUPT_MASK) & 32'h7fffffff); endproperty
	property p_low; INTERRUPT_PENDING[15:0] == 16'h0000; endproperty
	property p_lvl; s_low3 [*2] |=> INTERRUPT_PENDING[25]; endproperty
	property p_edge; s_fall3 |-> ##2 INTERRUPT_PENDING[25]; endproperty
	// lock state at reset is ignored, so skip the first edges
	property p_lock; $changed(PLL_LOCKED) && $past(ARST_N, 2) |-> ##2 SOURCE_FLAGS[5]; endproperty
	property p_pit; $changed(PERIODIC_TIMER_COUNT) && PERIODIC_TIMER_COUNT == 16'h0000 |=> SOURCE_FLAGS[4]; endproperty
	property p_tb; $changed(TIMEBASE_COUNT) && TIMEBASE_COUNT == TB_REF0 |-> ##[1:2] SOURCE_FLAGS[0]; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi differs from pin zero pending");
	a_vec: assert property (p_vec) else $error("nmi vector wrong");
	a_irq: assert property (p_irq) else $error("core request not masked pending");
	a_low: assert property (p_low) else $error("low pending bits set");
	a_lvl: assert property (p_lvl) else $error("level pin not pending");
	a_edge: assert property (p_edge) else $error("edge pin not pending");
	a_lock: assert property (p_lock) else $error("lock change not flagged");
	a_pit: assert property (p_pit) else $error("timer zero not flagged");
	a_tb: assert property (p_tb) else $error("time base match not flagged");
endmodule : intc_checker
bind system_interrupt_source_aggregator intc_checker intc_checker_inst (
	.CLOCK(CLOCK),
	.ARST_N(ARST_N),
	.IRQ_N(IRQ_N),
	.PIN_EDGE_MODE(PIN_EDGE_MODE),
	.INTERRUPT_MASK(INTERRUPT_MASK),
	.TB_REF0(TB_REF0),
	.PLL_LOCKED(PLL_LOCKED),
	.INTERRUPT_PENDING(INTERRUPT_PENDING),
	.CORE_IRQ(CORE_IRQ),
	.NMI_REQ(NMI_REQ),
	.NMI_VECTOR(NMI_VECTOR),
	.SOURCE_FLAGS(SOURCE_FLAGS),
	.TIMEBASE_COUNT(TIMEBASE_COUNT),
	.PERIODIC_TIMER_COUNT(PERIODIC_TIMER_COUNT)
);

// >>> verif/system_interrupt_source_aggregator_tb.sv
`timescale 1ns/10ps
module system_interrupt_source_aggregator_tb;
	import intc_pkg::*;
	logic clock = 0, arst_n = 0, locked = 0, irq, nmi;
	logic [7:0] irq_n = 8'hff, edge_mode = 8'h00, pin_clear = 8'h00;
	logic [31:0] mask = 32'h0, ref0 = 32'h0, ref1 = 32'h0, alarm = 32'h0, pend, tbc, cc, core_count, nmi_count;
	logic [5:0] en = 6'h0, clr = 6'h0, flags;
	logic [15:0] vec, pitc;
	logic [2:0] tb_lvl = 3'h0, clk_lvl = 3'h2, pit_lvl = 3'h4, lock_lvl = 3'h5;
	logic pit_run = 1;
	logic [15:0] pit_reload = 16'h0009, pit0;
	logic [31:0] tb0, cc0;
	int fail_count = 0, total_checks = 0, cycles = 0;
	// end levels included so both ends of the interleave are reached
	int lvl[6] = '{0, 3, 2, 7, 4, 5};
	system_interrupt_source_aggregator #(.SECOND_CYCLES(20), .TB_DIVIDE(2), .PIT_DIVIDE(2))
		system_interrupt_source_aggregator_inst (.CLOCK(clock), .ARST_N(arst_n), .IRQ_N(irq_n),
		.PIN_EDGE_MODE(edge_mode), .PIN_CLEAR(pin_clear), .INTERRUPT_MASK(mask), .TB_REF0(ref0),
		.TB_REF1(ref1), .TIMEBASE_LEVEL_FIELD(tb_lvl), .TIMEBASE_MATCH_FIRST_ENABLE(en[0]),
		.TIMEBASE_MATCH_SECOND_ENABLE(en[1]), .TIMEBASE_MATCH_FIRST_CLEAR(clr[0]),
		.TIMEBASE_MATCH_SECOND_CLEAR(clr[1]), .ALARM_VALUE(alarm), .CLOCK_LEVEL_FIELD(clk_lvl),
		.ALARM_ENABLE(en[2]), .SECONDS_ENABLE(en[3]), .ALARM_CLEAR(clr[2]), .SECONDS_CLEAR(clr[3]),
		.PERIODIC_TIMER_RUN(pit_run), .PERIODIC_TIMER_RELOAD(pit_reload), .PERIODIC_TIMER_LEVEL_FIELD(pit_lvl),
		.PERIODIC_TIMER_ENABLE(en[4]), .PERIODIC_TIMER_CLEAR(clr[4]), .PLL_LOCKED(locked),
		.LOCK_CHANGE_LEVEL_FIELD(lock_lvl), .LOCK_CHANGE_ENABLE(en[5]), .LOCK_CHANGE_CLEAR(clr[5]),
		.INTERRUPT_PENDING(pend), .CORE_IRQ(irq), .NMI_REQ(nmi), .NMI_VECTOR(vec), .SOURCE_FLAGS(flags),
		.TIMEBASE_COUNT(tbc), .CLOCK_COUNT(cc), .PERIODIC_TIMER_COUNT(pitc));
	core_model core_model_inst (.clock(clock), .arst_n(arst_n), .irq(irq), .nmi(nmi),
		.irq_count(core_count), .nmi_count(nmi_count));
	task tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task conclude();
		if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	// clock and a hang guard well beyond the expected run
	initial forever #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		tick(4);
		arst_n = 1;
		tick(2);
		// pin zero reaches the nmi whatever the mask says
		irq_n[0] = 0;
		mask = 32'h80000000;
		tick(3);
		chk("nmi", nmi, 1'h1);
		chk("vector", vec, NMI_VECTOR_OFFSET);
		chk("pin0 pending", pend, 32'h80000000);
		chk("pin0 irq", irq, 1'h0);
		irq_n[0] = 1;
		tick(3);
		chk("nmi off", nmi, 1'h0);
		// edge capture is sticky until cleared
		edge_mode[3] = 1;
		mask = 32'h02000000;
		irq_n[3] = 0;
		tick(1);
		irq_n[3] = 1;
		tick(3);
		chk("edge pending", pend, 32'h02000000);
		chk("edge irq", irq, 1'h1);
		pin_clear[3] = 1;
		tick(1);
		pin_clear[3] = 0;
		tick(3);
		chk("edge cleared", pend, 32'h0);
		edge_mode[3] = 0;
		// level pins walk down the interleaved bit order
		for (int i = 1; i < 8; i++) begin
			mask = 32'h80000000 >> (2 * i);
			irq_n[i] = 0;
			tick(3);
			chk("level pending", pend, mask);
			chk("level irq", irq, 1'h1);
			mask = ~mask;
			tick(2);
			chk("masked irq", irq, 1'h0);
			irq_n[i] = 1;
			tick(3);
			chk("released", pend, 32'h0);
		end
		// counters advance at their divided rates; the periodic timer holds while stopped
		pit_run = 0;
		pit0 = pitc;
		tb0 = tbc;
		cc0 = cc;
		tick(20);
		chk("periodic hold", {16'h0000, pitc}, {16'h0000, pit0});
		chk("time base rate", tbc, tb0 + 32'h0000000a);
		chk("seconds rate", cc, cc0 + 32'h00000001);
		pit_run = 1;
		// each internal source alone enabled; the rest must not post
		for (int s = 0; s < 6; s++) begin
			mask = 32'h40000000 >> (2 * lvl[s]);
			if (s < 2) tb_lvl = 3'(lvl[s]);
			else if (s < 4) clk_lvl = 3'(lvl[s]);
			else if (s == 4) pit_lvl = 3'(lvl[s]);
			else lock_lvl = 3'(lvl[s]);
			// clear a stale flag before enabling, else it posts at once and stays until cleared
			clr[s] = 1;
			tick(1);
			clr[s] = 0;
			en = 6'h01 << s;
			tick(2);
			if (s == 0) ref0 = tbc + 32'h8;
			if (s == 1) ref1 = tbc + 32'h8;
			if (s == 2) alarm = cc + 32'h2;
			if (s == 5) locked = 1;
			for (int w = 0; w < 200 && flags[s] !== 1'h1; w++) tick(1);
			chk("level post", pend & 32'h55550000, mask);
			chk("source irq", irq, 1'h1);
			clr[s] = 1;
			tick(1);
			clr[s] = 0;
			tick(3);
			chk("after clear", pend & 32'h55550000, 32'h0);
		end
		chk("core takes", core_count, 32'h0000000e);
		chk("nmi takes", nmi_count, 32'h1);
		conclude();
	end
endmodule : system_interrupt_source_aggregator_tb
